// ### src/spece_pkg.sv
package spece_pkg;

    // ------------------------------------------------------------
    // protocol bytes
    // ------------------------------------------------------------
    localparam logic [7:0]  MATCH_BYTE   = 8'h5a;
    localparam logic [7:0]  CMD_ERASE    = 8'hf0;
    localparam logic [7:0]  CMD_WRITE    = 8'h30;
    localparam logic [7:0]  CMD_RAMLD    = 8'h60;
    localparam logic [7:0]  CMD_SUM      = 8'h90;
    localparam logic [7:0]  CMD_ID       = 8'hc0;
    localparam logic [7:0]  CMD_STAT     = 8'hc3;
    localparam logic [7:0]  CMD_LOCK     = 8'hfa;
    localparam logic [7:0]  ERR_PRE_A    = 8'ha1;
    localparam logic [7:0]  ERR_PRE_B    = 8'ha3;
    localparam logic [7:0]  ERR_BAUD     = 8'h62;
    localparam logic [7:0]  ERR_CMD      = 8'h63;
    localparam logic [7:0]  ERASED_BYTE  = 8'hff;
    localparam logic [7:0]  CHIP_AREA    = 8'hcf;
    localparam logic [3:0]  ERR_REP_A    = 4'h3;
    localparam logic [3:0]  ERR_REP_B    = 4'h6;
    localparam logic [3:0]  ERR_LAST     = 4'h8;
    localparam logic [1:0]  PADDR_LAST   = 2'h3;

    // ------------------------------------------------------------
    // flash map and link
    // ------------------------------------------------------------
    localparam logic [15:0] FLASH_LO     = 16'hc000;
    localparam logic [15:0] FLASH_HI     = 16'hffff;
    localparam logic [15:0] BLANK_LO     = 16'hffe0;
    localparam logic [2:0]  BAUD_SEL_DEF = 3'h6;
    localparam int          TXQ_WIDTH    = 8;
    localparam int          TXQ_DEPTH    = 16;

    typedef enum logic [12:0] {
        ST_MATCH  = 13'h0001,
        ST_BAUD   = 13'h0002,
        ST_BAUDSW = 13'h0004,
        ST_CMD    = 13'h0008,
        ST_PADDR  = 13'h0010,
        ST_BLANK  = 13'h0020,
        ST_PCNT   = 13'h0040,
        ST_PSTR   = 13'h0080,
        ST_AREA   = 13'h0100,
        ST_ERASE  = 13'h0200,
        ST_SUM    = 13'h0400,
        ST_SUMTX  = 13'h0800,
        ST_HALT   = 13'h1000
    } spece_state_t;

    // returns {valid, rate select}; select 0 is fastest, 6 keeps the default
    function automatic logic [3:0] spece_baud_lut(input logic [7:0] code);
        case (code)
            8'h04:   spece_baud_lut = 4'h8;
            8'h05:   spece_baud_lut = 4'h9;
            8'h06:   spece_baud_lut = 4'ha;
            8'h07:   spece_baud_lut = 4'hb;
            8'h0a:   spece_baud_lut = 4'hc;
            8'h18:   spece_baud_lut = 4'hd;
            8'h28:   spece_baud_lut = 4'he;
            default: spece_baud_lut = 4'h0;
        endcase
    endfunction

endpackage

// ### src/spece_fifo.sv
`timescale 1ns/1ps
module spece_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire  logic             core_clk,
    input  wire  logic             resetn,
    input  wire  logic             in_valid,
    output logic                   in_ready,
    input  wire  logic [WIDTH-1:0] in_data,
    output logic                   out_valid,
    input  wire  logic             out_ready,
    output logic [WIDTH-1:0]       out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready  = count != (AW+1)'(DEPTH);
    assign out_valid = count != '0;
    assign out_data  = mem[rd_ptr];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end
endmodule

// ### src/spece_core.sv
`timescale 1ns/1ps
module spece_core
    import spece_pkg::*;
(
    input  wire  logic        core_clk,
    input  wire  logic        resetn,
    input  wire  logic        rx_valid,
    output logic              rx_ready,
    input  wire  logic [7:0]  rx_data,
    input  wire  logic        rx_error,
    output logic              tx_valid,
    input  wire  logic        tx_ready,
    output logic [7:0]        tx_data,
    output logic [2:0]        baud_sel,
    input  wire  logic        sec_lock,
    output logic              lock_clear,
    output logic [15:0]       flash_addr,
    input  wire  logic [7:0]  flash_rdata,
    output logic              erase_go,
    output logic [3:0]        erase_first,
    output logic [3:0]        erase_last,
    output logic              erase_chip,
    input  wire  logic        erase_done,
    output logic              mode_go,
    output logic [7:0]        mode_cmd,
    output logic              halted
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    spece_state_t state;
    spece_state_t next_state;
    logic [2:0]   baud_pend;
    logic [2:0]   next_baud_pend;
    logic [2:0]   next_baud_sel;
    logic [7:0]   next_mode_cmd;
    logic [1:0]   paddr_cnt;
    logic [1:0]   next_paddr_cnt;
    logic [31:0]  pw_addrs;
    logic [31:0]  next_pw_addrs;
    logic [15:0]  next_flash_addr;
    logic [7:0]   pw_idx;
    logic [7:0]   next_pw_idx;
    logic [7:0]   pw_len;
    logic [7:0]   next_pw_len;
    logic         blank;
    logic         next_blank;
    logic [15:0]  sum;
    logic [15:0]  next_sum;
    logic         sum_idx;
    logic         next_sum_idx;
    logic [3:0]   err_cnt;
    logic [3:0]   next_err_cnt;
    logic [7:0]   err_code;
    logic [7:0]   next_err_code;
    logic         err_tx;
    logic         next_err_tx;
    logic [7:0]   area;
    logic [7:0]   next_area;
    logic         next_erase_go;
    logic         next_mode_go;
    logic         next_lock_clear;
    logic         push_valid;
    logic         push_ready;
    logic [7:0]   push_data;
    logic         rx_fire;
    logic [3:0]   baud_hit;
    logic         cmd_known;
    logic         needs_auth;

    assign rx_fire    = rx_valid && rx_ready;
    assign baud_hit   = spece_baud_lut(rx_data);
    assign halted     = state == ST_HALT && !err_tx;
    assign erase_first = area[7:4];
    assign erase_last  = area[3:0];
    assign erase_chip  = area == CHIP_AREA;
    assign needs_auth  = rx_data == CMD_ERASE || rx_data == CMD_WRITE
                      || rx_data == CMD_RAMLD;
    assign cmd_known   = needs_auth || rx_data == CMD_SUM || rx_data == CMD_ID
                      || rx_data == CMD_STAT || rx_data == CMD_LOCK;

    // ------------------------------------------------------------
    // transmit queue
    // ------------------------------------------------------------
    spece_fifo #(
        .WIDTH (TXQ_WIDTH),
        .DEPTH (TXQ_DEPTH)
    ) u_txq (
        .core_clk  (core_clk),
        .resetn    (resetn),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (push_data),
        .out_valid (tx_valid),
        .out_ready (tx_ready),
        .out_data  (tx_data)
    );

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_comb begin
        next_state      = state;
        next_baud_pend  = baud_pend;
        next_baud_sel   = baud_sel;
        next_mode_cmd   = mode_cmd;
        next_paddr_cnt  = paddr_cnt;
        next_pw_addrs   = pw_addrs;
        next_flash_addr = flash_addr;
        next_pw_idx     = pw_idx;
        next_pw_len     = pw_len;
        next_blank      = blank;
        next_sum        = sum;
        next_sum_idx    = sum_idx;
        next_err_cnt    = err_cnt;
        next_err_code   = err_code;
        next_err_tx     = err_tx;
        next_area       = area;
        next_erase_go   = 1'b0;
        next_mode_go    = 1'b0;
        next_lock_clear = 1'b0;
        push_valid      = 1'b0;
        push_data       = rx_data;
        rx_ready        = 1'b0;
        case (state)
            ST_MATCH: begin
                rx_ready = push_ready;
                if (rx_fire && !rx_error && rx_data == MATCH_BYTE) begin
                    push_valid    = 1'b1;
                    next_baud_sel = BAUD_SEL_DEF;
                    next_state    = ST_BAUD;
                end
            end
            ST_BAUD: begin
                rx_ready = push_ready;
                if (rx_fire) begin
                    if (baud_hit[3] && !rx_error) begin
                        push_valid     = 1'b1;
                        next_baud_pend = baud_hit[2:0];
                        next_state     = ST_BAUDSW;
                    end else begin
                        next_err_code = ERR_BAUD;
                        next_err_cnt  = '0;
                        next_err_tx   = 1'b1;
                        next_state    = ST_HALT;
                    end
                end
            end
            ST_BAUDSW: begin
                // new rate only after the echo has left the queue
                if (!tx_valid) begin
                    next_baud_sel = baud_pend;
                    next_state    = ST_CMD;
                end
            end
            ST_CMD: begin
                rx_ready = push_ready;
                if (rx_fire) begin
                    if (cmd_known && !rx_error) begin
                        push_valid    = 1'b1;
                        next_mode_cmd = rx_data;
                        if (needs_auth) begin
                            next_paddr_cnt = '0;
                            next_state     = ST_PADDR;
                            if (sec_lock && rx_data != CMD_ERASE) begin
                                next_state = ST_HALT;
                            end
                        end else if (rx_data == CMD_SUM) begin
                            next_flash_addr = FLASH_LO;
                            next_sum        = '0;
                            next_state      = ST_SUM;
                        end else begin
                            next_mode_go = 1'b1;
                        end
                    end else begin
                        next_err_code = ERR_CMD;
                        next_err_cnt  = '0;
                        next_err_tx   = 1'b1;
                        next_state    = ST_HALT;
                    end
                end
            end
            ST_PADDR: begin
                rx_ready = 1'b1;
                if (rx_fire) begin
                    next_pw_addrs  = {pw_addrs[23:0], rx_data};
                    next_paddr_cnt = paddr_cnt + 1'b1;
                    if (rx_error) begin
                        next_state = ST_HALT;
                    end else if (paddr_cnt == PADDR_LAST) begin
                        next_flash_addr = BLANK_LO;
                        next_blank      = 1'b1;
                        next_state      = ST_BLANK;
                    end
                end
            end
            ST_BLANK: begin
                if (flash_rdata != ERASED_BYTE) begin
                    next_blank = 1'b0;
                end
                if (flash_addr == FLASH_HI) begin
                    next_flash_addr = pw_addrs[31:16];
                    next_state      = ST_PCNT;
                end else begin
                    next_flash_addr = flash_addr + 16'h0001;
                end
            end
            ST_PCNT: begin
                next_pw_len     = flash_rdata;
                next_pw_idx     = '0;
                next_flash_addr = pw_addrs[15:0];
                if (blank || flash_rdata == '0) begin
                    next_state   = mode_cmd == CMD_ERASE ? ST_AREA : ST_CMD;
                    next_mode_go = mode_cmd != CMD_ERASE;
                end else begin
                    next_state = ST_PSTR;
                end
            end
            ST_PSTR: begin
                rx_ready = 1'b1;
                if (rx_fire) begin
                    next_pw_idx     = pw_idx + 8'h01;
                    next_flash_addr = flash_addr + 16'h0001;
                    if (rx_error || rx_data != flash_rdata) begin
                        next_state = ST_HALT;
                    end else if (pw_idx == pw_len - 8'h01) begin
                        next_state   = mode_cmd == CMD_ERASE ? ST_AREA : ST_CMD;
                        next_mode_go = mode_cmd != CMD_ERASE;
                    end
                end
            end
            ST_AREA: begin
                rx_ready = 1'b1;
                if (rx_fire) begin
                    if (rx_error || (sec_lock && rx_data != CHIP_AREA)) begin
                        next_state = ST_HALT;
                    end else begin
                        next_area       = rx_data;
                        next_erase_go   = 1'b1;
                        next_lock_clear = rx_data == CHIP_AREA;
                        next_state      = ST_ERASE;
                    end
                end
            end
            ST_ERASE: begin
                if (erase_done) begin
                    next_flash_addr = FLASH_LO;
                    next_sum        = '0;
                    next_state      = ST_SUM;
                end
            end
            ST_SUM: begin
                next_sum = sum + {8'h00, flash_rdata};
                if (flash_addr == FLASH_HI) begin
                    next_sum_idx = 1'b0;
                    next_state   = ST_SUMTX;
                end else begin
                    next_flash_addr = flash_addr + 16'h0001;
                end
            end
            ST_SUMTX: begin
                push_valid = 1'b1;
                push_data  = sum_idx ? sum[7:0] : sum[15:8];
                if (push_ready) begin
                    next_sum_idx = 1'b1;
                    if (sum_idx) begin
                        next_state = ST_CMD;
                    end
                end
            end
            ST_HALT: begin
                rx_ready = 1'b1;
                if (err_tx) begin
                    push_valid = 1'b1;
                    push_data  = err_cnt < ERR_REP_A ? ERR_PRE_A
                               : err_cnt < ERR_REP_B ? ERR_PRE_B : err_code;
                    if (push_ready) begin
                        next_err_cnt = err_cnt + 4'h1;
                        next_err_tx  = err_cnt != ERR_LAST;
                    end
                end
            end
            default: begin
                next_state = ST_HALT;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state      <= ST_MATCH;
            baud_pend  <= BAUD_SEL_DEF;
            baud_sel   <= BAUD_SEL_DEF;
            mode_cmd   <= '0;
            paddr_cnt  <= '0;
            pw_addrs   <= '0;
            flash_addr <= '0;
            pw_idx     <= '0;
            pw_len     <= '0;
            blank      <= 1'b0;
            sum        <= '0;
            sum_idx    <= 1'b0;
            err_cnt    <= '0;
            err_code   <= '0;
            err_tx     <= 1'b0;
            area       <= '0;
            erase_go   <= 1'b0;
            mode_go    <= 1'b0;
            lock_clear <= 1'b0;
        end else begin
            state      <= next_state;
            baud_pend  <= next_baud_pend;
            baud_sel   <= next_baud_sel;
            mode_cmd   <= next_mode_cmd;
            paddr_cnt  <= next_paddr_cnt;
            pw_addrs   <= next_pw_addrs;
            flash_addr <= next_flash_addr;
            pw_idx     <= next_pw_idx;
            pw_len     <= next_pw_len;
            blank      <= next_blank;
            sum        <= next_sum;
            sum_idx    <= next_sum_idx;
            err_cnt    <= next_err_cnt;
            err_code   <= next_err_code;
            err_tx     <= next_err_tx;
            area       <= next_area;
            erase_go   <= next_erase_go;
            mode_go    <= next_mode_go;
            lock_clear <= next_lock_clear;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_match_echo: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_MATCH && rx_fire && !rx_error && rx_data == MATCH_BYTE
        |-> push_valid && push_data == MATCH_BYTE ##1 state == ST_BAUD)
        else $error("matching byte not echoed");
    a_nomatch_quiet: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_MATCH && rx_fire && rx_data != MATCH_BYTE
        |-> !push_valid ##1 state == ST_MATCH)
        else $error("unknown byte answered");
    a_bad_baud_run: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_BAUD && rx_fire && !baud_hit[3]
        |=> state == ST_HALT && err_tx && err_cnt == 4'h0 && err_code == ERR_BAUD)
        else $error("bad baud byte not flagged");
    a_err_end: assert property (@(posedge core_clk) disable iff (!resetn)
        err_tx && err_cnt == ERR_LAST && push_ready
        |-> push_data == err_code ##1 !err_tx && halted)
        else $error("error run did not end in halt");
    a_halt_silent: assert property (@(posedge core_clk) disable iff (!resetn)
        halted |-> !push_valid ##1 halted)
        else $error("halted engine became active");
    a_lock_sector: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_AREA && rx_fire && sec_lock && rx_data != CHIP_AREA
        |=> state == ST_HALT && !erase_go)
        else $error("sector erase taken under lock");
    a_chip_unlock: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_AREA && rx_fire && !rx_error && rx_data == CHIP_AREA
        |=> erase_go && lock_clear && erase_chip)
        else $error("whole erase left lock");
    a_lock_write: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_CMD && rx_fire && sec_lock && cmd_known
        && (rx_data == CMD_WRITE || rx_data == CMD_RAMLD)
        |=> state == ST_HALT ##1 !mode_go)
        else $error("locked write mode started");
    a_pw_miss: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_PSTR && rx_fire && (rx_error || rx_data != flash_rdata)
        |=> halted [*2])
        else $error("password miss not halted");
    a_sum_order: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_SUMTX && !sum_idx && push_ready
        |-> push_data == sum[15:8] ##1 push_data == $past(sum[7:0]))
        else $error("checksum byte order wrong");
    a_sum_back: assert property (@(posedge core_clk) disable iff (!resetn)
        state == ST_SUMTX && sum_idx && push_ready |=> state == ST_CMD)
        else $error("no return to command wait");
endmodule

// ### tb/spece_far.sv
`timescale 1ns/1ps
module spece_far
    import spece_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        lock_init,
    input  wire logic [15:0] flash_addr,
    output logic      [7:0]  flash_rdata,
    input  wire logic        erase_go,
    input  wire logic [3:0]  erase_first,
    input  wire logic [3:0]  erase_last,
    input  wire logic        lock_clear,
    output logic             erase_done,
    output logic             sec_lock
);
    logic [7:0] mem [0:16383];
    int         busy = 0;
    // outside the flash window the bus shows a moving pattern, never stale data
    assign flash_rdata = flash_addr[15:14] == 2'h3 ? mem[flash_addr[13:0]] : ~flash_addr[7:0];
    always @(posedge core_clk) begin
        erase_done <= busy == 1;
        if (busy > 0) busy <= busy - 1;
        // lock level is loaded while the device sits in reset
        if (!resetn) sec_lock <= lock_init;
        else if (erase_go && lock_clear) sec_lock <= 1'b0;
        if (erase_go) begin
            busy <= 20;
            for (int a = 0; a < 16384; a++)
                if ({2'h3, a[13:12]} >= erase_first && {2'h3, a[13:12]} <= erase_last)
                    mem[a] <= ERASED_BYTE;
        end
    end
endmodule

// ### tb/tb_serial_prom_erase_command_engine.sv
`timescale 1ns/1ps
module tb_serial_prom_erase_command_engine
    import spece_pkg::*;
;
    logic        core_clk = 1'b0, resetn = 1'b0, rx_valid = 1'b0, rx_error = 1'b0;
    logic        tx_ready = 1'b0, rx_ready, tx_valid, sec_lock, lock_clear, erase_go;
    logic        erase_chip, erase_done, mode_go, halted, e_chip, e_clr;
    logic        lock_init = 1'b0;
    logic [7:0]  rx_data = 8'h00, rnd = 8'h56, tx_data, mode_cmd, flash_rdata, e_mode, c;
    logic [3:0]  erase_first, erase_last, e_first, e_last;
    logic [2:0]  baud_sel;
    logic [15:0] flash_addr, s;
    logic [7:0]  q[$], b[7];
    int          fails = 0, n_tests = 0, n_erase, n_mode;
    spece_core u_dut(.core_clk, .resetn, .rx_valid, .rx_ready, .rx_data, .rx_error,
        .tx_valid, .tx_ready, .tx_data, .baud_sel, .sec_lock, .lock_clear, .flash_addr,
        .flash_rdata, .erase_go, .erase_first, .erase_last, .erase_chip, .erase_done,
        .mode_go, .mode_cmd, .halted);
    spece_far u_far(.core_clk, .resetn, .lock_init, .flash_addr, .flash_rdata, .erase_go, .erase_first,
        .erase_last, .lock_clear, .erase_done, .sec_lock);
    always #2 core_clk = ~core_clk;
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    // checksum of the flash as it must read after sectors lo..hi are erased
    function automatic logic [15:0] fsum(input logic [3:0] lo, input logic [3:0] hi);
        logic [15:0] t;
        t = 16'h0000;
        for (int a = 0; a < 16384; a++)
            t += ({2'h3, a[13:12]} >= lo && {2'h3, a[13:12]} <= hi) ? 8'hff : u_far.mem[a];
        return t;
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // the uart side stalls at random; a byte counts when valid meets ready
    always @(negedge core_clk) begin
        rnd = lfsr(rnd);
        if (tx_valid === 1'b1 && rnd[0]) q.push_back(tx_data);
        tx_ready = rnd[0];
        if (erase_go === 1'b1) begin
            n_erase++;
            {e_clr, e_chip, e_first, e_last} = {lock_clear, erase_chip, erase_first, erase_last};
        end
        if (mode_go === 1'b1) begin
            n_mode++;
            e_mode = mode_cmd;
        end
    end
    task automatic fill(input logic blank);
        for (int a = 0; a < 16384; a++) begin
            rnd = lfsr(rnd);
            u_far.mem[a] = (blank && a >= 16352) ? 8'hff : rnd;
        end
        u_far.mem[0] = 8'h02;
    endtask
    task automatic rst(input logic lk);
        resetn = 1'b0;
        lock_init = lk;
        {n_erase, n_mode} = 0;
        q = {};
        repeat (4) @(negedge core_clk);
        resetn = 1'b1;
    endtask
    task automatic send(input logic [7:0] d);
        rx_valid = 1'b1;
        rx_data = d;
        #1;
        for (int i = 0; i < 40000 && rx_ready !== 1'b1; i++) begin
            @(negedge core_clk);
            #1;
        end
        if (rx_ready !== 1'b1) fails++;
        @(negedge core_clk);
    endtask
    task automatic go(input logic [7:0] sq[$], input logic [7:0] e[$]);
        q = {};
        foreach (sq[i]) send(sq[i]);
        rx_valid = 1'b0;
        for (int i = 0; i < 40000 && q.size() < e.size(); i++) @(negedge core_clk);
        repeat (60) @(negedge core_clk);
        chk("tx count", 16'(e.size()), 16'(q.size()));
        foreach (e[i]) if (i < q.size()) chk("tx byte", {8'h00, e[i]}, {8'h00, q[i]});
    endtask
    initial begin
        #360000;
        fails++;
        close_out();
    end
    initial begin
        fill(1'b0);
        b = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h0a, 8'h18, 8'h28};
        for (int i = 0; i < 7; i++) begin
            c = i < 3 ? CMD_ID : i < 5 ? CMD_STAT : CMD_LOCK;
            rst(1'b0);
            go({MATCH_BYTE, b[i], c}, {MATCH_BYTE, b[i], c});
            chk("rate", 16'(i), {13'h0000, baud_sel});
            chk("mode", {4'h1, 4'h0, c}, {4'(n_mode), 4'h0, e_mode});
        end
        rst(1'b0);
        s = fsum(4'hc, 4'hd);
        go({MATCH_BYTE, 8'h04, CMD_ERASE, 8'hc0, 8'h00, 8'hc0, 8'h01, u_far.mem[1],
            u_far.mem[2], 8'hcd}, {MATCH_BYTE, 8'h04, CMD_ERASE, s[15:8], s[7:0]});
        chk("sector", 16'h10cd, {4'(n_erase), 2'h0, e_clr, e_chip, e_first, e_last});
        fill(1'b0);
        rst(1'b0);
        go({MATCH_BYTE, 8'h28, CMD_ERASE, 8'hc0, 8'h00, 8'hc0, 8'h01, ~u_far.mem[1],
            u_far.mem[2], 8'hcd}, {MATCH_BYTE, 8'h28, CMD_ERASE});
        chk("pw halt", 16'h0100, {7'h00, halted, 4'(n_erase), 4'h0});
        rst(1'b1);
        go({MATCH_BYTE, 8'h28, CMD_WRITE}, {MATCH_BYTE, 8'h28, CMD_WRITE});
        chk("lock halt", 16'h0100, {7'h00, halted, 4'(n_mode), 4'h0});
        rst(1'b0);
        go({MATCH_BYTE, 8'h11, MATCH_BYTE}, {MATCH_BYTE, ERR_PRE_A, ERR_PRE_A, ERR_PRE_A,
            ERR_PRE_B, ERR_PRE_B, ERR_PRE_B, ERR_BAUD, ERR_BAUD, ERR_BAUD});
        chk("baud halt", 16'h0001, {15'h0000, halted});
        rst(1'b0);
        go({MATCH_BYTE, 8'h28, 8'h55}, {MATCH_BYTE, 8'h28, ERR_PRE_A, ERR_PRE_A, ERR_PRE_A,
            ERR_PRE_B, ERR_PRE_B, ERR_PRE_B, ERR_CMD, ERR_CMD, ERR_CMD});
        fill(1'b1);
        rst(1'b1);
        s = fsum(4'hc, 4'hf);
        go({MATCH_BYTE, 8'h28, CMD_ERASE, 8'hc0, 8'h00, 8'hc0, 8'h01, CHIP_AREA},
            {MATCH_BYTE, 8'h28, CMD_ERASE, s[15:8], s[7:0]});
        chk("chip", 16'h13cf, {4'(n_erase), 2'h0, e_clr, e_chip, e_first, e_last});
        go({CMD_SUM}, {CMD_SUM, s[15:8], s[7:0]});
        go({CMD_WRITE, 8'hc0, 8'h00, 8'hc0, 8'h01}, {CMD_WRITE});
        chk("write", {4'h1, 4'h0, CMD_WRITE}, {4'(n_mode), 4'h0, e_mode});
        close_out();
    end
endmodule
